// ### hdl/aux_pin_control.sv
// Contract
// - After reset terminal 0 carries the contender line and terminal 1 link power status.
// - Bit 7 selects terminal 0 role: 0 dedicated contender signal, 1 general-purpose pin 0.
// - Bit 15 selects terminal 1 role: 0 dedicated link power status, 1 general-purpose pin 1.
// - Bit 29 set inverts input and output polarity of terminal 3; reset leaves it noninverted.
// - Bit 28 clear keeps terminal 3 in high impedance; set drives it; reset is clear.
// - With its output enabled terminal 3 drives the value last written to bit 24.
// - Bit 21 set inverts input and output polarity of terminal 2; reset leaves it noninverted.
// - Bit 20 clear keeps terminal 2 in high impedance; set drives it; reset is clear.
// - With its output enabled terminal 2 drives the value last written to bit 16.
// - Bit 13 governs terminal 1 polarity only while bit 15 is set.
// - Bit 12 governs terminal 1 output enable only while bit 15 is set; it resets to 1.
// - With bit 15 set and output enabled, terminal 1 drives the value written to bit 8.
// - Bit 5 governs terminal 0 polarity only while bit 7 is set.
// - Bit 4 governs terminal 0 output enable only while bit 7 is set; it resets to 1.
// - With bit 7 set and output enabled, terminal 0 drives the value written to bit 0.
// - All reserved bits of the control register read as zero.
`timescale 1ns/10ps
`default_nettype none
`include "auxpc_defs.svh"

module aux_pin_control #(
  parameter int ADDR_W = 8,
  parameter int PIN_COUNT = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire auxpc_pkg::auxpc_word_type avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output auxpc_pkg::auxpc_word_type avs_readdata,
  output logic avs_waitrequest,
  // Dedicated link signals
  input wire logic bus_manager_contender_signal,
  input wire logic link_power_status_signal,
  // Terminals
  input wire logic [PIN_COUNT-1:0] aux_pin_in,
  output logic [PIN_COUNT-1:0] aux_pin_out,
  output logic [PIN_COUNT-1:0] aux_pin_oe,
  // Sampled terminal levels after polarity
  output logic [PIN_COUNT-1:0] aux_pin_value
);
  import auxpc_pkg::*;

  if (ADDR_W < 8) begin : g_addr_check
    $error("aux_pin_control: ADDR_W must hold offset 0xfc");
  end
  if (PIN_COUNT != 4) begin : g_count_check
    $error("aux_pin_control: exactly four terminals are supported");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then accept

  auxpc_bus_state_type bus_state_reg;
  auxpc_bus_state_type bus_state_next;
  auxpc_word_type ctrl_reg;
  auxpc_word_type ctrl_next;
  auxpc_word_type lane_mask;
  logic hit;
  logic accept;

  assign hit = (avs_address == ADDR_W'(`AUXPC_CTRL_OFFSET));
  assign accept = (bus_state_reg == AUXPC_BUS_ANSWER);

  always_comb begin
    case (bus_state_reg)
      AUXPC_BUS_IDLE: begin
        bus_state_next = (avs_read || avs_write) ? AUXPC_BUS_ANSWER : AUXPC_BUS_IDLE;
      end
      AUXPC_BUS_ANSWER: begin
        bus_state_next = AUXPC_BUS_IDLE;
      end
      default: begin
        bus_state_next = AUXPC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_state_reg <= AUXPC_BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // Waitrequest is a flop copy of the state so the output has no decode glitch
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= (bus_state_next != AUXPC_BUS_ANSWER);
    end
  end

  // Read data loaded in the wait cycle; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_state_reg == AUXPC_BUS_IDLE && avs_read) begin
      avs_readdata <= hit ? (ctrl_reg & `AUXPC_CTRL_WMASK) : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always_comb begin
    lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    ctrl_next = ctrl_reg;
    if (accept && avs_write && hit) begin
      // Reserved bits never store, so they cannot leak into readback
      ctrl_next = (ctrl_reg & ~(lane_mask & `AUXPC_CTRL_WMASK))
                | (avs_writedata & lane_mask & `AUXPC_CTRL_WMASK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= `AUXPC_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-terminal field routing

  logic [PIN_COUNT-1:0] general_purpose;
  logic [PIN_COUNT-1:0] polarity_invert;
  logic [PIN_COUNT-1:0] output_enable;
  logic [PIN_COUNT-1:0] drive_value;
  logic [PIN_COUNT-1:0] dedicated_value;

  assign general_purpose = {1'b1, 1'b1,
                            ctrl_reg[`AUXPC_PIN1_FSEL_BIT],
                            ctrl_reg[`AUXPC_PIN0_FSEL_BIT]};
  assign polarity_invert = {ctrl_reg[`AUXPC_PIN3_INV_BIT],
                            ctrl_reg[`AUXPC_PIN2_INV_BIT],
                            ctrl_reg[`AUXPC_PIN1_INV_BIT],
                            ctrl_reg[`AUXPC_PIN0_INV_BIT]};
  assign output_enable = {ctrl_reg[`AUXPC_PIN3_OE_BIT],
                          ctrl_reg[`AUXPC_PIN2_OE_BIT],
                          ctrl_reg[`AUXPC_PIN1_OE_BIT],
                          ctrl_reg[`AUXPC_PIN0_OE_BIT]};
  assign drive_value = {ctrl_reg[`AUXPC_PIN3_DRIVE_BIT],
                        ctrl_reg[`AUXPC_PIN2_DRIVE_BIT],
                        ctrl_reg[`AUXPC_PIN1_DRIVE_BIT],
                        ctrl_reg[`AUXPC_PIN0_DRIVE_BIT]};
  // Terminals 2 and 3 have no dedicated role, so their source is never used
  assign dedicated_value = {1'b0, 1'b0, link_power_status_signal,
                            bus_manager_contender_signal};

  ////////////////////////////////////////////////////////////////////////////
  // Terminal cells

  genvar pin_idx;
  generate
    for (pin_idx = 0; pin_idx < PIN_COUNT; pin_idx++) begin : g_pin
      auxpc_pin_cell u_cell (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .general_purpose(general_purpose[pin_idx]),
        .polarity_invert(polarity_invert[pin_idx]),
        .output_enable(output_enable[pin_idx]),
        .drive_value(drive_value[pin_idx]),
        .dedicated_value(dedicated_value[pin_idx]),
        .pin_in(aux_pin_in[pin_idx]),
        .pin_out(aux_pin_out[pin_idx]),
        .pin_oe(aux_pin_oe[pin_idx]),
        .pin_value(aux_pin_value[pin_idx])
      );
    end
  endgenerate

endmodule

`default_nettype wire

// ### include/auxpc_defs.svh
`ifndef AUXPC_DEFS_SVH
`define AUXPC_DEFS_SVH

// Register map
`define AUXPC_CTRL_OFFSET 8'hfc
`define AUXPC_CTRL_RESET 32'h0000_1010
`define AUXPC_CTRL_WMASK 32'h3131_b1b1

// Field positions
`define AUXPC_PIN0_DRIVE_BIT 0
`define AUXPC_PIN0_OE_BIT 4
`define AUXPC_PIN0_INV_BIT 5
`define AUXPC_PIN0_FSEL_BIT 7
`define AUXPC_PIN1_DRIVE_BIT 8
`define AUXPC_PIN1_OE_BIT 12
`define AUXPC_PIN1_INV_BIT 13
`define AUXPC_PIN1_FSEL_BIT 15
`define AUXPC_PIN2_DRIVE_BIT 16
`define AUXPC_PIN2_OE_BIT 20
`define AUXPC_PIN2_INV_BIT 21
`define AUXPC_PIN3_DRIVE_BIT 24
`define AUXPC_PIN3_OE_BIT 28
`define AUXPC_PIN3_INV_BIT 29

`endif

// ### include/auxpc_pkg.sv
`default_nettype none
package auxpc_pkg;

  typedef enum logic {
    AUXPC_BUS_IDLE,
    AUXPC_BUS_ANSWER
  } auxpc_bus_state_type;

  typedef logic [31:0] auxpc_word_type;

endpackage
`default_nettype wire

// ### hdl/auxpc_pin_cell.sv
`timescale 1ns/10ps
`default_nettype none

module auxpc_pin_cell (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control fields
  input wire logic general_purpose,
  input wire logic polarity_invert,
  input wire logic output_enable,
  input wire logic drive_value,
  // Dedicated function source
  input wire logic dedicated_value,
  // Terminal
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_value
);

  ////////////////////////////////////////////////////////////////////////////
  // Output path; dedicated role always drives the terminal
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      // Only a dedicated role drives in reset; general-purpose terminals stay released
      pin_oe <= !general_purpose;
    end else if (general_purpose) begin
      pin_out <= drive_value ^ polarity_invert;
      pin_oe <= output_enable;
    end else begin
      pin_out <= dedicated_value;
      pin_oe <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input path, inverted only in general-purpose role
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_value <= 1'b0;
    end else begin
      pin_value <= pin_in ^ (general_purpose & polarity_invert);
    end
  end

endmodule

`default_nettype wire

// ### verification/auxpc_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "auxpc_defs.svh"
module auxpc_ctrl_sva #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire auxpc_pkg::auxpc_word_type avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire auxpc_pkg::auxpc_word_type avs_readdata,
  input wire logic avs_waitrequest,
  // Terminals
  input wire logic bus_manager_contender_signal,
  input wire logic link_power_status_signal,
  input wire logic [3:0] aux_pin_in,
  input wire logic [3:0] aux_pin_out,
  input wire logic [3:0] aux_pin_oe,
  input wire logic [3:0] aux_pin_value
);
  import auxpc_pkg::*;
  auxpc_word_type m_reg;
  auxpc_word_type lane;
  logic hit;
  logic [3:0] exp_oe;
  logic [3:0] exp_out;
  logic [3:0] exp_val;
  assign lane = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign hit = !avs_waitrequest && avs_address == ADDR_W'(`AUXPC_CTRL_OFFSET);
  assign exp_oe = {m_reg[28], m_reg[20], !m_reg[15] | m_reg[12], !m_reg[7] | m_reg[4]};
  assign exp_out = {m_reg[24] ^ m_reg[29], m_reg[16] ^ m_reg[21],
    m_reg[15] ? m_reg[8] ^ m_reg[13] : link_power_status_signal,
    m_reg[7] ? m_reg[0] ^ m_reg[5] : bus_manager_contender_signal};
  // Dedicated roles never invert the input
  assign exp_val = aux_pin_in ^ {m_reg[29], m_reg[21], m_reg[15] & m_reg[13], m_reg[7] & m_reg[5]};
  // Mirror of the word; only accepted writes to the mapped offset land
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      m_reg <= `AUXPC_CTRL_RESET;
    end else if (hit && avs_write) begin
      m_reg <= (m_reg & ~lane) | (avs_writedata & lane & `AUXPC_CTRL_WMASK);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  read_back_a: assert property (hit && avs_read |-> avs_readdata == m_reg)
    else $error("readback differs from written word");
  rsvd_zero_a: assert property (
    !avs_waitrequest |-> (avs_readdata & ~`AUXPC_CTRL_WMASK) == 32'h0000_0000)
    else $error("reserved bit reads one");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  pins_oe_a: assert property (
    1'b1 |=> aux_pin_oe == $past(exp_oe))
    else $error("output enable wrong");
  ded_oe_a: assert property (!m_reg[7] && !m_reg[15] |=> aux_pin_oe[1:0] == 2'b11)
    else $error("dedicated terminal not driven");
  pin01_out_a: assert property (
    1'b1 |=> aux_pin_out[1:0] == $past(exp_out[1:0]))
    else $error("terminal 0 or 1 drive wrong");
  pin23_out_a: assert property (1'b1 |=> aux_pin_out[3:2] == $past(exp_out[3:2]))
    else $error("terminal 2 or 3 drive wrong");
  in_pol_a: assert property (
    1'b1 |=> aux_pin_value == $past(exp_val))
    else $error("input level polarity wrong");
  cover property (hit && avs_write);
  cover property (hit && avs_read);
  cover property (m_reg[7] && m_reg[15]);
endmodule
`default_nettype wire

// ### verification/auxpc_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module auxpc_board_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Terminals
  input wire logic [3:0] aux_pin_out,
  input wire logic [3:0] aux_pin_oe,
  input wire logic [3:0] ext_level,
  output logic [3:0] aux_pin_in,
  // Link device
  output logic bus_manager_contender_signal,
  output logic link_power_status_signal
);
  // Link lines keep moving so a stuck dedicated path shows
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      {bus_manager_contender_signal, link_power_status_signal} <= 2'b10;
    end else begin
      {bus_manager_contender_signal, link_power_status_signal} <=
        {!link_power_status_signal, bus_manager_contender_signal};
    end
  end
  // A released terminal settles to the board level
  assign aux_pin_in = (aux_pin_oe & aux_pin_out) | (~aux_pin_oe & ext_level);
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "auxpc_defs.svh"
`define CHK(n, g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  import auxpc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic avs_waitrequest, bus_manager_contender_signal, link_power_status_signal;
  logic [7:0] avs_address = 8'h00;
  logic [3:0] avs_byteenable = 4'h0;
  logic [3:0] ext_level = 4'ha;
  logic [3:0] aux_pin_in, aux_pin_out, aux_pin_oe, aux_pin_value;
  auxpc_word_type avs_writedata = 32'h0;
  auxpc_word_type avs_readdata, em, q;
  int err_count = 0;
  int n_checks = 0;
  logic [35:0] tab [5] = '{36'hf_ffffffff, 36'h1_00000000, 36'h6_00208080,
    36'hf_11019191, 36'hf_00000000};
  always #12.5 core_clk = ~core_clk;
  aux_pin_control dut (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .bus_manager_contender_signal, .link_power_status_signal, .aux_pin_in,
    .aux_pin_out, .aux_pin_oe, .aux_pin_value);
  auxpc_board_model partner (.core_clk, .rst_n, .aux_pin_out, .aux_pin_oe, .ext_level,
    .aux_pin_in, .bus_manager_contender_signal, .link_power_status_signal);
  ////////////////////////////////////////
  task automatic bus(input logic wr, input logic [7:0] a, input auxpc_word_type d,
    input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input auxpc_word_type e);
    bus(1'b0, a, 32'h0, 4'h0);
    `CHK("readdata", q, e)
  endtask
  task automatic pins_chk;
    logic [3:0] gp, oe, out, inv;
    gp = {2'b11, em[15], em[7]};
    oe = {em[28], em[20], !em[15] | em[12], !em[7] | em[4]};
    inv = {em[29], em[21], em[13], em[5]};
    out = {em[24], em[16], em[8], em[0]} ^ inv;
    repeat (2) @(posedge core_clk);
    `CHK("pin_oe", aux_pin_oe, oe)
    `CHK("pin_out", aux_pin_out & gp, out & gp)
    `CHK("pin_val", aux_pin_value & gp, (((oe & out) | (~oe & ext_level)) ^ inv) & gp)
  endtask
  task automatic test_done;
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    `CHK("rst_oe", aux_pin_oe, 4'h3)
    rst_n <= 1'b1;
    em = `AUXPC_CTRL_RESET;
    rd_chk(8'hfc, em);
    pins_chk;
    foreach (tab[i]) begin
      bus(1'b1, 8'hfc, tab[i][31:0], tab[i][35:32]);
      for (int b = 0; b < 4; b++) if (tab[i][32+b]) em[8*b+:8] =
        tab[i][8*b+:8] & 8'(`AUXPC_CTRL_WMASK >> (8 * b));
      pins_chk;
      rd_chk(8'hfc, em);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK("rst_oe", aux_pin_oe, 4'h3)
    rst_n <= 1'b1;
    em = `AUXPC_CTRL_RESET;
    rd_chk(8'hfc, em);
    pins_chk;
    bus(1'b1, 8'hf8, 32'hffffffff, 4'hf);
    rd_chk(8'hf8, 32'h0);
    rd_chk(8'hfc, em);
    test_done;
  end
  initial begin
    repeat (1000) @(posedge core_clk);
    err_count++;
    test_done;
  end
endmodule
bind aux_pin_control auxpc_ctrl_sva #(.ADDR_W(ADDR_W)) sva (.core_clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .bus_manager_contender_signal, .link_power_status_signal, .aux_pin_in, .aux_pin_out,
  .aux_pin_oe, .aux_pin_value);
`default_nettype wire
